/* File: design/tc16_pkg.sv */
// Package with register indices, field positions, reset values and mode codes
// of the 16-bit timer/counter with capture and compare.
// Assumes a 32-bit APB with one register per aligned word, byte address = index * 4.
package tc16_pkg;

    // ------------------------------------------------------------------
    // Register indices (byte address is four times the index)
    // ------------------------------------------------------------------
    localparam logic [7:0] IDX_CONTROL   = 8'h90;
    localparam logic [7:0] IDX_FORCE     = 8'h92;
    localparam logic [7:0] IDX_COUNT_LO  = 8'h94;
    localparam logic [7:0] IDX_COUNT_HI  = 8'h95;
    localparam logic [7:0] IDX_CAPT_LO   = 8'h96;
    localparam logic [7:0] IDX_CAPT_HI   = 8'h97;
    localparam logic [7:0] IDX_CMPA_LO   = 8'h98;
    localparam logic [7:0] IDX_CMPA_HI   = 8'h99;
    localparam logic [7:0] IDX_CMPB_LO   = 8'h9A;
    localparam logic [7:0] IDX_CMPB_HI   = 8'h9B;
    localparam logic [7:0] IDX_STATUS    = 8'h9C;

    // ------------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------------
    localparam int CTL_MODE_LSB   = 0;
    localparam int CTL_COMA_LSB   = 4;
    localparam int CTL_COMB_LSB   = 6;
    localparam int CTL_EDGE_BIT   = 8;
    localparam int CTL_FILT_BIT   = 9;
    localparam int CTL_SRC_BIT    = 10;
    localparam int FORCE_A_BIT    = 0;
    localparam int FORCE_B_BIT    = 1;
    localparam int STS_CAPT_BIT   = 0;
    localparam int STS_MA_BIT     = 1;
    localparam int STS_MB_BIT     = 2;

    // ------------------------------------------------------------------
    // Reset values and constants
    // ------------------------------------------------------------------
    localparam logic [15:0] VALUE_RESET  = 16'h0000;
    localparam logic [15:0] TOP_FULL     = 16'hFFFF;
    localparam logic [15:0] TOP_8BIT     = 16'h00FF;
    localparam logic [15:0] TOP_9BIT     = 16'h01FF;
    localparam logic [15:0] TOP_10BIT    = 16'h03FF;
    localparam logic [31:0] DATA_ZERO    = 32'h0000_0000;
    localparam int          FILTER_SAMPLES = 4;

    // ------------------------------------------------------------------
    // Waveform modes and compare output settings
    // ------------------------------------------------------------------
    localparam logic [3:0] MODE_NORMAL    = 4'h0;
    localparam logic [3:0] MODE_CTC_CMPA  = 4'h4;
    localparam logic [3:0] MODE_PFC_CAPT  = 4'h8;
    localparam logic [3:0] MODE_PC_CAPT   = 4'hA;
    localparam logic [3:0] MODE_CTC_CAPT  = 4'hC;
    localparam logic [3:0] MODE_FAST_CAPT = 4'hE;
    localparam logic [1:0] COM_OFF        = 2'h0;
    localparam logic [1:0] COM_TOGGLE     = 2'h1;
    localparam logic [1:0] COM_CLEAR      = 2'h2;
    localparam logic [1:0] COM_SET        = 2'h3;

endpackage

/* File: design/capture_filter.sv */
// Noise canceller for the synchronised capture input.
// Assumes its input already passed two flip-flops in the pclk domain.
`timescale 1ns/1ps
`default_nettype none

module capture_filter
    import tc16_pkg::*;
#(
    parameter int SAMPLES = FILTER_SAMPLES
) (
    input  wire logic pclk,
    input  wire logic presetn,
    input  wire logic clk_en,
    input  wire logic filter_enable,
    input  wire logic din,
    output var  logic dout
);

    typedef struct packed {
        logic [SAMPLES-1:0] hist;
        logic               out;
    } filt_state_t;

    filt_state_t q;
    filt_state_t d;

    // ------------------------------------------------------------------
    // Filter
    // ------------------------------------------------------------------
    // Output follows only after SAMPLES equal samples; bypassed when disabled.
    always_comb begin
        d = q;
        d.hist = {q.hist[SAMPLES-2:0], din};
        if (!filter_enable) begin
            d.out = din;
        end else if (&d.hist) begin
            d.out = 1'b1;
        end else if (~|d.hist) begin
            d.out = 1'b0;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            q <= '0;
        end else if (clk_en) begin
            q <= d;
        end
    end

    assign dout = q.out;

endmodule

`default_nettype wire

/* File: design/tc16_regs.sv */
// Top of the 16-bit timer/counter: counter, capture and two compare channels
// reached byte-wise over APB, with a shared high-byte holding register.
// Assumes timer_tick is a one-cycle pulse from the prescaler on pclk.
//
// Summary of operation
// - Force bits act only in non-PWM modes.
// - Force strobe applies compare action immediately.
// - Force sets no flag, never clears counter.
// - Force bits always read back zero.
// - Low byte at base, high byte at base+1.
// - Four registers at fixed indices, reset zero.
// - Counter readable and writable as 16 bits.
// - One holding byte shared by all registers.
// - Counter write blocks matches next tick.
// - Capture loads counter value into capture register.
// - Capture register may serve as top.
// - Capture reads are coherent via holding byte.
// - Compares checked against counter every tick.
// - Match sets flag and drives waveform.
// - Compare writes commit both bytes together.
// - Edge select: zero falling, one rising.
// - Capture event sets capture flag.
// - Capture disabled while capture is top.
// - Noise filter needs four equal samples.
`timescale 1ns/1ps
`default_nettype none

module tc16_regs
    import tc16_pkg::*;
#(
    parameter int ADDR_W = 12
) (
    input  wire logic              pclk,
    input  wire logic              presetn,
    input  wire logic              clk_en,
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [ADDR_W-1:0] paddr,
    input  wire logic [31:0]       pwdata,
    output var  logic [31:0]       prdata,
    output var  logic              pready,
    output var  logic              pslverr,
    input  wire logic              timer_tick,
    input  wire logic              capture_input_pin,
    input  wire logic              comparator_out,
    output var  logic              waveform_out_a,
    output var  logic              waveform_out_b,
    output var  logic              capture_flag,
    output var  logic              match_flag_a,
    output var  logic              match_flag_b
);

    typedef struct packed {
        logic [15:0] cnt;
        logic [15:0] icr;
        logic [15:0] ocra;
        logic [15:0] ocrb;
        logic [7:0]  temp;
        logic [3:0]  mode;
        logic [1:0]  com_a;
        logic [1:0]  com_b;
        logic        edge_sel;
        logic        filt_en;
        logic        src_sel;
        logic        icf;
        logic        mfa;
        logic        mfb;
        logic        block;
        logic        wa;
        logic        wb;
        logic [1:0]  sync1;
        logic [1:0]  sync2;
        logic        cap_prev;
        logic [31:0] prdata;
        logic        pready;
        logic        pslverr;
    } tc_state_t;

    tc_state_t q;
    tc_state_t d;
    logic      cap_filt;
    logic      setup;
    logic      done_wr;
    logic [7:0] idx;
    logic      cap_event;
    logic      match_a;
    logic      match_b;

    // ------------------------------------------------------------------
    // Decoding helpers
    // ------------------------------------------------------------------
    // Non-PWM modes are normal and the two clear-on-match modes.
    function automatic logic is_pwm(input logic [3:0] m);
        return !(m == MODE_NORMAL || m == MODE_CTC_CMPA || m == MODE_CTC_CAPT);
    endfunction

    function automatic logic capt_is_top(input logic [3:0] m);
        return m == MODE_PFC_CAPT || m == MODE_PC_CAPT || m == MODE_CTC_CAPT || m == MODE_FAST_CAPT;
    endfunction

    // Top value per mode; the counter only counts up, phase-correct modes included.
    function automatic logic [15:0] top_of(input logic [3:0] m, input logic [15:0] a, input logic [15:0] c);
        case (m)
            4'h1, 4'h5: return TOP_8BIT;
            4'h2, 4'h6: return TOP_9BIT;
            4'h3, 4'h7: return TOP_10BIT;
            4'h4, 4'h9, 4'hB, 4'hF: return a;
            4'h8, 4'hA, 4'hC, 4'hE: return c;
            default: return TOP_FULL;
        endcase
    endfunction

    // Compare output action; in PWM modes the bottom event does the opposite.
    function automatic logic wave_next(input logic cur, input logic [1:0] com, input logic pwm,
                                       input logic hit, input logic bottom);
        logic r;
        r = cur;
        if (hit) begin
            case (com)
                COM_TOGGLE: r = pwm ? cur : !cur;
                COM_CLEAR:  r = 1'b0;
                COM_SET:    r = 1'b1;
                default:    r = cur;
            endcase
        end else if (bottom && pwm) begin
            case (com)
                COM_CLEAR: r = 1'b1;
                COM_SET:   r = 1'b0;
                default:   r = cur;
            endcase
        end
        return r;
    endfunction

    // Splits a 16-bit value by byte index; the high byte reads the holding byte.
    function automatic logic [7:0] byte_of(input logic [15:0] v, input logic hi, input logic [7:0] t);
        return hi ? t : v[7:0];
    endfunction

    assign idx     = paddr[9:2];
    assign setup   = psel && !penable;
    assign done_wr = psel && penable && q.pready && pwrite;

    // ------------------------------------------------------------------
    // Capture input path
    // ------------------------------------------------------------------
    capture_filter #(
        .SAMPLES (FILTER_SAMPLES)
    ) u_filter (
        .pclk          (pclk),
        .presetn       (presetn),
        .clk_en        (clk_en),
        .filter_enable (q.filt_en),
        .din           (q.src_sel ? q.sync2[1] : q.sync2[0]),
        .dout          (cap_filt)
    );

    // Chosen edge of the filtered input, gated off while capture is top.
    assign cap_event = !capt_is_top(q.mode)
                     && (q.edge_sel ? (cap_filt && !q.cap_prev) : (!cap_filt && q.cap_prev));

    // Matches are evaluated on ticks only, and never right after a counter write.
    assign match_a = timer_tick && !q.block && (q.cnt == q.ocra);
    assign match_b = timer_tick && !q.block && (q.cnt == q.ocrb);

    // ------------------------------------------------------------------
    // Next-state logic
    // ------------------------------------------------------------------
    always_comb begin
        logic [15:0] top;
        logic        wrap;
        logic        bottom;
        top    = top_of(q.mode, q.ocra, q.icr);
        wrap   = 1'b0;
        bottom = 1'b0;
        d = q;
        // Each source has its own synchroniser; the select acts after the second flop only.
        d.sync1    = {comparator_out, capture_input_pin};
        d.sync2    = q.sync1;
        d.cap_prev = cap_filt;
        d.pready   = 1'b0;

        // Counter advance, with clear on top in every mode.
        if (timer_tick) begin
            wrap = (q.cnt == top);
            d.cnt = wrap ? VALUE_RESET : q.cnt + 16'h0001;
            bottom = wrap;
            d.block = 1'b0;
        end
        d.wa = wave_next(q.wa, q.com_a, is_pwm(q.mode), match_a, bottom);
        d.wb = wave_next(q.wb, q.com_b, is_pwm(q.mode), match_b, bottom);

        if (cap_event) begin
            d.icr = q.cnt;
        end

        // Setup phase: answer next cycle; low-byte reads freeze the high byte.
        if (setup) begin
            d.pready  = 1'b1;
            d.pslverr = 1'b0;
            d.prdata  = DATA_ZERO;
            if (!pwrite) begin
                case (idx)
                    IDX_CONTROL: d.prdata[10:0] = {q.src_sel, q.filt_en, q.edge_sel, q.com_b, q.com_a, q.mode};
                    IDX_FORCE:   d.prdata = DATA_ZERO;
                    IDX_COUNT_LO, IDX_COUNT_HI: begin
                        d.prdata[7:0] = byte_of(q.cnt, idx[0], q.temp);
                        if (!idx[0]) d.temp = q.cnt[15:8];
                    end
                    IDX_CAPT_LO, IDX_CAPT_HI: begin
                        d.prdata[7:0] = byte_of(q.icr, idx[0], q.temp);
                        if (!idx[0]) d.temp = q.icr[15:8];
                    end
                    IDX_CMPA_LO, IDX_CMPA_HI: begin
                        d.prdata[7:0] = byte_of(q.ocra, idx[0], q.temp);
                        if (!idx[0]) d.temp = q.ocra[15:8];
                    end
                    IDX_CMPB_LO, IDX_CMPB_HI: begin
                        d.prdata[7:0] = byte_of(q.ocrb, idx[0], q.temp);
                        if (!idx[0]) d.temp = q.ocrb[15:8];
                    end
                    IDX_STATUS:  d.prdata[2:0] = {q.mfb, q.mfa, q.icf};
                    default:     d.pslverr = 1'b1;
                endcase
            end else if (idx < IDX_CONTROL || idx > IDX_STATUS || idx == 8'h91 || idx == 8'h93) begin
                d.pslverr = 1'b1;
            end
        end

        // Access phase: writes take effect at the completing edge.
        if (done_wr) begin
            case (idx)
                IDX_CONTROL: begin
                    d.mode     = pwdata[CTL_MODE_LSB +: 4];
                    d.com_a    = pwdata[CTL_COMA_LSB +: 2];
                    d.com_b    = pwdata[CTL_COMB_LSB +: 2];
                    d.edge_sel = pwdata[CTL_EDGE_BIT];
                    d.filt_en  = pwdata[CTL_FILT_BIT];
                    d.src_sel  = pwdata[CTL_SRC_BIT];
                end
                IDX_FORCE: begin
                    // Strobes use the setting in force now; no flag, no clear.
                    if (!is_pwm(q.mode)) begin
                        d.wa = wave_next(q.wa, q.com_a, 1'b0, pwdata[FORCE_A_BIT], 1'b0);
                        d.wb = wave_next(q.wb, q.com_b, 1'b0, pwdata[FORCE_B_BIT], 1'b0);
                    end
                end
                IDX_COUNT_HI, IDX_CAPT_HI, IDX_CMPA_HI, IDX_CMPB_HI: begin
                    d.temp = pwdata[7:0];
                end
                IDX_COUNT_LO: begin
                    d.cnt   = {q.temp, pwdata[7:0]};
                    d.block = 1'b1;
                end
                IDX_CAPT_LO: d.icr  = {q.temp, pwdata[7:0]};
                IDX_CMPA_LO: d.ocra = {q.temp, pwdata[7:0]};
                IDX_CMPB_LO: d.ocrb = {q.temp, pwdata[7:0]};
                IDX_STATUS: begin
                    if (pwdata[STS_CAPT_BIT]) d.icf = 1'b0;
                    if (pwdata[STS_MA_BIT])   d.mfa = 1'b0;
                    if (pwdata[STS_MB_BIT])   d.mfb = 1'b0;
                end
                default: d.temp = d.temp;
            endcase
        end

        // Hardware sets come last so an event beats a same-cycle clear.
        if (cap_event) d.icf = 1'b1;
        if (match_a)   d.mfa = 1'b1;
        if (match_b)   d.mfb = 1'b1;
    end

    // ------------------------------------------------------------------
    // State register
    // ------------------------------------------------------------------
    // All registers reset to zero; clk_en low freezes everything, bus included.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            q <= '0;
        end else if (clk_en) begin
            q <= d;
        end
    end

    assign prdata         = q.prdata;
    assign pready         = q.pready;
    assign pslverr        = q.pslverr;
    assign waveform_out_a = q.wa;
    assign waveform_out_b = q.wb;
    assign capture_flag   = q.icf;
    assign match_flag_a   = q.mfa;
    assign match_flag_b   = q.mfb;

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    sequence s_wr(logic [7:0] i);
        done_wr && clk_en && idx == i;
    endsequence

    property p_force_pwm;
        @(posedge pclk) disable iff (!presetn)
        s_wr(IDX_FORCE) ##0 (is_pwm(q.mode) && !timer_tick) |=> $stable(waveform_out_a) && $stable(waveform_out_b);
    endproperty
    a_force_pwm: assert property (p_force_pwm) else $error("force acted in a PWM mode");

    property p_force_tgl;
        @(posedge pclk) disable iff (!presetn)
        s_wr(IDX_FORCE) ##0 (pwdata[FORCE_A_BIT] && !is_pwm(q.mode) && q.com_a == COM_TOGGLE && !timer_tick)
        |=> waveform_out_a != $past(waveform_out_a);
    endproperty
    a_force_tgl: assert property (p_force_tgl) else $error("force strobe did not toggle output");

    property p_force_noflag;
        @(posedge pclk) disable iff (!presetn)
        s_wr(IDX_FORCE) ##0 (!match_a && !timer_tick) |=> match_flag_a == $past(match_flag_a) && $stable(q.cnt);
    endproperty
    a_force_noflag: assert property (p_force_noflag) else $error("force changed flag or counter");

    property p_force_rd;
        @(posedge pclk) disable iff (!presetn)
        (setup && !pwrite && clk_en && idx == IDX_FORCE) |=> prdata == DATA_ZERO && pready;
    endproperty
    a_force_rd: assert property (p_force_rd) else $error("force register read nonzero");

    property p_block;
        @(posedge pclk) disable iff (!presetn)
        (timer_tick && clk_en && q.block && !match_flag_a && !match_flag_b) |=> !match_flag_a && !match_flag_b;
    endproperty
    a_block: assert property (p_block) else $error("match not blocked after counter write");

    property p_capture;
        @(posedge pclk) disable iff (!presetn)
        (cap_event && clk_en && !done_wr) |=> q.icr == $past(q.cnt) && capture_flag;
    endproperty
    a_capture: assert property (p_capture) else $error("capture did not load counter and flag");

    property p_capt_top;
        @(posedge pclk) disable iff (!presetn)
        (capt_is_top(q.mode) && clk_en && !done_wr) |=> $stable(q.icr);
    endproperty
    a_capt_top: assert property (p_capt_top) else $error("capture ran while capture is top");

    property p_cmp_commit;
        @(posedge pclk) disable iff (!presetn)
        s_wr(IDX_CMPA_LO) |=> q.ocra == {$past(q.temp), $past(pwdata[7:0])};
    endproperty
    a_cmp_commit: assert property (p_cmp_commit) else $error("compare write not committed whole");

    property p_match;
        @(posedge pclk) disable iff (!presetn)
        (timer_tick && clk_en && !q.block && q.cnt == q.ocrb) |=> match_flag_b;
    endproperty
    a_match: assert property (p_match) else $error("compare match B not flagged");

endmodule

`default_nettype wire

/* File: dv/tc16_regs_test.sv */
// Self-checking bench for the 16-bit timer register block, driven over APB.
// Assumes tc16_pkg and tc16_regs are compiled first and answer with zero wait states.
`timescale 1ns/1ps
`default_nettype none

module tc16_regs_test
    import tc16_pkg::*;
;
    // ------------------------------------------------------------------
    // Signals and expectation queue
    // ------------------------------------------------------------------
    typedef struct packed {
        logic        rd;
        logic [31:0] data;
        logic        err;
    } note_t;

    logic        pclk              = 1'b0;
    logic        presetn           = 1'b0;
    logic        psel              = 1'b0;
    logic        penable           = 1'b0;
    logic        pwrite            = 1'b0;
    logic [11:0] paddr             = 12'h000;
    logic [31:0] pwdata            = 32'h0000_0000;
    logic        timer_tick        = 1'b0;
    logic        capture_input_pin = 1'b0;
    logic        clk_en            = 1'b1;
    logic        comparator_out    = 1'b0;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        waveform_out_a;
    logic        waveform_out_b;
    logic        capture_flag;
    logic        match_flag_a;
    logic        match_flag_b;
    note_t       exp_q[$];
    note_t       cur_note;
    int          fails             = 0;
    int          samples_checked   = 0;
    logic [31:0] rv;

    // The clock enable and the comparator source are driven so both paths get exercised.
    tc16_regs dut_u (
        .pclk              (pclk),
        .presetn           (presetn),
        .clk_en            (clk_en),
        .psel              (psel),
        .penable           (penable),
        .pwrite            (pwrite),
        .paddr             (paddr),
        .pwdata            (pwdata),
        .prdata            (prdata),
        .pready            (pready),
        .pslverr           (pslverr),
        .timer_tick        (timer_tick),
        .capture_input_pin (capture_input_pin),
        .comparator_out    (comparator_out),
        .waveform_out_a    (waveform_out_a),
        .waveform_out_b    (waveform_out_b),
        .capture_flag      (capture_flag),
        .match_flag_a      (match_flag_a),
        .match_flag_b      (match_flag_b)
    );

    // Free-running 125 MHz clock.
    always #4 pclk = ~pclk;

    // ------------------------------------------------------------------
    // Compare, bus and timer tasks
    // ------------------------------------------------------------------
    task automatic check_word(input string name, input logic [31:0] e, input logic [31:0] g);
        samples_checked++;
        if (g !== e) begin
            fails++;
            $display("ERROR %s expected %h seen %h", name, e, g);
        end
    endtask

    task automatic check_bit(input string name, input logic e, input logic g);
        samples_checked++;
        if (g !== e) begin
            fails++;
            $display("ERROR %s expected %b seen %b", name, e, g);
        end
    endtask

    // One APB transfer; the answer is judged by the monitor, not here.
    // An idle cycle follows so no signal is assigned twice in one time step.
    task automatic xfer(input logic w, input logic [7:0] idx, input logic [31:0] wd,
                        input logic [31:0] ed, input logic ee);
        exp_q.push_back({~w, ed, ee});
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= 12'({idx, 2'b00});
        pwdata  <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        psel    <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask

    task automatic wr(input logic [7:0] idx, input logic [31:0] v);
        xfer(1'b1, idx, v, DATA_ZERO, 1'b0);
    endtask

    task automatic rd(input logic [7:0] idx, input logic [31:0] v);
        xfer(1'b0, idx, DATA_ZERO, v, 1'b0);
    endtask

    // High byte first so the low-byte write commits both halves.
    task automatic w16(input logic [7:0] idx, input logic [15:0] v);
        wr(8'(idx + 8'h01), 32'(v[15:8]));
        wr(idx, 32'(v[7:0]));
    endtask

    task automatic r16(input logic [7:0] idx, input logic [15:0] v);
        rd(idx, 32'(v[7:0]));
        rd(8'(idx + 8'h01), 32'(v[15:8]));
    endtask

    task automatic tick;
        timer_tick <= 1'b1;
        @(posedge pclk);
        timer_tick <= 1'b0;
        @(posedge pclk);
    endtask

    // Expected order is capture, match A, match B, waveform A, waveform B.
    task automatic flags(input logic [4:0] e);
        #1;
        check_bit("capture_flag", e[4], capture_flag);
        check_bit("match_flag_a", e[3], match_flag_a);
        check_bit("match_flag_b", e[2], match_flag_b);
        check_bit("waveform_out_a", e[1], waveform_out_a);
        check_bit("waveform_out_b", e[0], waveform_out_b);
        @(posedge pclk);
    endtask

    task automatic test_done;
        if (fails == 0 && samples_checked > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    // Monitor: each completed transfer takes the oldest note off the queue.
    always @(posedge pclk) begin
        if (psel && penable && pready === 1'b1) begin
            cur_note = exp_q.pop_front();
            check_bit("pslverr", cur_note.err, pslverr);
            if (cur_note.rd) begin
                check_word("prdata", cur_note.data, prdata);
            end
        end else if (presetn && !(psel && penable) && pready !== 1'b0) begin
            check_bit("pready", 1'b0, pready);
        end
    end

    // ------------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------------
    initial begin
        rv = $urandom(32'h10f7_6d8c);
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        for (int i = 0; i < 8; i++) rd(8'(IDX_COUNT_LO + i), DATA_ZERO);
        flags(5'b0_0000);
        xfer(1'b0, 8'h80, DATA_ZERO, DATA_ZERO, 1'b1);
        xfer(1'b1, 8'h80, 32'hFFFF_FFFF, DATA_ZERO, 1'b1);
        w16(IDX_CMPA_LO, 16'hA55A);
        r16(IDX_CMPA_LO, 16'hA55A);
        // A high byte staged for one register lands in another: the holding byte is shared.
        wr(IDX_CMPB_HI, 32'h0000_00C3);
        wr(IDX_CAPT_LO, 32'h0000_003C);
        r16(IDX_CMPB_LO, 16'h0000);
        rd(IDX_CAPT_LO, 32'h0000_003C);
        rd(IDX_CMPA_HI, 32'h0000_00C3);
        repeat (4) begin
            rv = $urandom;
            w16(IDX_CMPB_LO, rv[15:0]);
            r16(IDX_CMPB_LO, rv[15:0]);
        end
        // Counter write blocks the first match, the next tick matches.
        wr(IDX_CONTROL, 32'h0000_0010);
        w16(IDX_CMPA_LO, 16'h1234);
        w16(IDX_COUNT_LO, 16'h1234);
        tick;
        flags(5'b0_0000);
        r16(IDX_COUNT_LO, 16'h1235);
        w16(IDX_CMPA_LO, 16'h1235);
        w16(IDX_CMPB_LO, 16'h1235);
        tick;
        flags(5'b0_1110);
        // Forced strobes: act in non-PWM modes only, set no flag, never clear the count.
        wr(IDX_CONTROL, 32'h0000_00D0);
        wr(IDX_STATUS, 32'h0000_0007);
        wr(IDX_FORCE, 32'h0000_0002);
        flags(5'b0_0011);
        rd(IDX_FORCE, DATA_ZERO);
        wr(IDX_CONTROL, 32'h0000_009E);
        wr(IDX_FORCE, 32'h0000_0003);
        flags(5'b0_0011);
        wr(IDX_CONTROL, 32'h0000_0014);
        w16(IDX_COUNT_LO, 16'h0050);
        wr(IDX_FORCE, 32'h0000_0001);
        flags(5'b0_0001);
        r16(IDX_COUNT_LO, 16'h0050);
        // Capture on the rising edge, then the falling edge, then with capture as top.
        wr(IDX_CONTROL, 32'h0000_0110);
        w16(IDX_COUNT_LO, 16'h0A0B);
        capture_input_pin <= 1'b1;
        repeat (12) @(posedge pclk);
        flags(5'b1_0001);
        rd(IDX_STATUS, 32'h0000_0001);
        rd(IDX_CONTROL, 32'h0000_0110);
        r16(IDX_CAPT_LO, 16'h0A0B);
        wr(IDX_CONTROL, 32'h0000_0010);
        w16(IDX_COUNT_LO, 16'h0C0D);
        capture_input_pin <= 1'b0;
        repeat (12) @(posedge pclk);
        r16(IDX_CAPT_LO, 16'h0C0D);
        wr(IDX_CONTROL, 32'h0000_001C);
        w16(IDX_COUNT_LO, 16'h0E0F);
        capture_input_pin <= 1'b1;
        repeat (12) @(posedge pclk);
        capture_input_pin <= 1'b0;
        repeat (12) @(posedge pclk);
        r16(IDX_CAPT_LO, 16'h0C0D);
        // Comparator as capture source, then a tick while the clock enable is low.
        wr(IDX_CONTROL, 32'h0000_0510);
        w16(IDX_COUNT_LO, 16'h1111);
        comparator_out <= 1'b1;
        repeat (12) @(posedge pclk);
        r16(IDX_CAPT_LO, 16'h1111);
        clk_en <= 1'b0;
        tick;
        clk_en <= 1'b1;
        r16(IDX_COUNT_LO, 16'h1111);
        tick;
        r16(IDX_COUNT_LO, 16'h1112);
        repeat (4) @(posedge pclk);
        if (exp_q.size() != 0) fails++;
        test_done;
    end

    // Watchdog: the whole run needs well under a thousand transfers.
    initial begin
        repeat (20000) @(posedge pclk);
        fails++;
        test_done;
    end

endmodule

`default_nettype wire
